// [core/mpir_regs.sv]
// Pin control, interrupt and option register bank
`include "mpir_map.svh"
`default_nettype none
// Operation
// [RL1] Program-counter high latch at 0Ah keeps up to three low bits.
// [RL2] Pull-down register 0Bh: low nibble port A, high nibble port B, 0 enables.
// [RL3] Open-drain register 0Ch: bit n set makes port B pin n open-drain.
// [RL4] Pull-high register 0Dh: bit n clear enables port B pin n pull-high.
// [RL5] Mask register 0Eh: bit0 timer, bit1 port change, bit2 external pin enables.
// [RL6] Mask register bits 6..3 read as zero.
// [RL7] Wake from sleep with global enable clear resumes after sleep.
// [RL8] Wake from sleep with global enable set vectors to 008h.
// [RL9] Taken interrupt clears global enable in hardware.
// [RL10] Interrupt return instruction sets global enable again.
// [RL11] Flags 0Fh bit0 timer, bit1 port change; only software clears them.
// [RL12] Flag bit 2 set on selected external pin edge, held until cleared.
// [RL13] Flag register bits 7..3 read as zero.
// [RL14] Seven-bit option register loaded from accumulator by option instruction only.
// [RL15] Option bits reset to one except edge select, which resets zero.
// [RL16] Three-bit prescale ratio: timer 1:2..1:256, watchdog 1:1..1:128.
// [RL17] Prescale target bit 3: one watchdog, zero timer.
// [RL18] Counter edge bit 4: one falling, zero rising edge.
// [RL19] Clock select bit 5: one external pin, zero instruction clock.
// [RL20] Edge select bit 6: one rising, zero falling edge.
// [RL21] Direction registers loaded from accumulator by direction instruction, operand 05h..07h.
// [RL22] Direction bit one makes input, zero drives; all reset to one.
// [RL23] Pulls switch off on pins configured as outputs.
// [RL24] Flag register read returns flags ANDed with mask bits.
// [RL25] Unimplemented latch and register bits ignore writes, read zero.
module mpir_regs
  import mpir_pkg::*;
#(
  parameter int PCH_BITS = 3
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] working_operand_reg_i,
  input wire logic option_load_i,
  input wire logic dir_load_instr_i,
  input wire logic [7:0] dir_sel_i,
  input wire logic irq_return_instr_i,
  input wire logic sleep_instr_i,
  input wire logic timer_ovf_i,
  input wire logic port_change_i,
  input wire logic ext_pin_i,
  output logic [7:0] rdata_o,
  output logic [7:0] pc_high_latch_o,
  output logic [3:0] porta_pulldown_n_o,
  output logic [3:0] portb_pulldown_n_o,
  output logic [7:0] portb_opendrain_en_o,
  output logic [7:0] portb_pullup_n_o,
  output logic [7:0] port_a_dir_o,
  output logic [7:0] port_b_dir_o,
  output logic [7:0] port_c_dir_o,
  output logic [2:0] prescale_ratio_o,
  output logic prescale_target_o,
  output logic counter_edge_select_o,
  output logic timer_clk_select_o,
  output logic ext_edge_polarity_o,
  output logic sleeping_o,
  output logic wake_o,
  output logic vector_take_o,
  output logic [10:0] vector_addr_o
);
  // ****************************************
  // Checks
  // ****************************************
  initial begin
    if (PCH_BITS < 1 || PCH_BITS > 3) begin
      $error("PCH_BITS must be 1 to 3");
    end
  end

  localparam logic [7:0] PCH_MASK = 8'((9'h001 << PCH_BITS) - 9'h001);
  localparam logic [7:0] RST_PD = `MPIR_RST_PULL;
  localparam logic [6:0] RST_OPT = `MPIR_RST_OPTION;

  // ****************************************
  // State
  // ****************************************
  logic [7:0] pch_ff;
  logic [7:0] pd_ff;
  logic [7:0] od_ff;
  logic [7:0] pu_ff;
  logic [7:0] mask_ff;
  logic [7:0] flag_ff;
  logic [6:0] option_ff;
  logic [7:0] dir_a_ff;
  logic [7:0] dir_b_ff;
  logic [7:0] dir_c_ff;
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic tmr_meta_ff;
  logic tmr_sync_ff;
  logic tmr_last_ff;
  logic pchg_meta_ff;
  logic pchg_sync_ff;
  logic pchg_last_ff;
  mpir_state_t state_ff;
  logic [7:0] nxt_flag;
  logic [7:0] events;
  logic irq_hit;
  logic wake_hit;
  logic wr_mask;
  logic wr_flag;
  mpir_flag_if flag_if ();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_mask = clk_en_i && wr_en_i && hit(addr_i, `MPIR_ADDR_MASK);
  assign wr_flag = clk_en_i && wr_en_i && hit(addr_i, `MPIR_ADDR_FLAG);

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      tmr_meta_ff <= 1'b0;
      tmr_sync_ff <= 1'b0;
      pchg_meta_ff <= 1'b0;
      pchg_sync_ff <= 1'b0;
      tmr_last_ff <= 1'b0;
      pchg_last_ff <= 1'b0;
    end else if (clk_en_i) begin
      ext_meta_ff <= ext_pin_i;
      ext_sync_ff <= ext_meta_ff;
      tmr_meta_ff <= timer_ovf_i;
      tmr_sync_ff <= tmr_meta_ff;
      pchg_meta_ff <= port_change_i;
      pchg_sync_ff <= pchg_meta_ff;
      tmr_last_ff <= tmr_sync_ff;
      pchg_last_ff <= pchg_sync_ff;
    end
  end

  assign flag_if.ext_pin_sync = ext_sync_ff;
  assign flag_if.ext_edge_polarity = option_ff[`MPIR_OPT_EDGE];

  mpir_edge_det u_edge (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .enable_i(clk_en_i),
    .flag_if(flag_if)
  );

  // ****************************************
  // Pin control registers
  // ****************************************
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pch_ff <= `MPIR_RST_ZERO;
      pd_ff <= `MPIR_RST_PULL;
      od_ff <= `MPIR_RST_ZERO;
      pu_ff <= `MPIR_RST_PULL;
    end else if (clk_en_i && wr_en_i) begin
      if (hit(addr_i, `MPIR_ADDR_PCHI)) begin
        pch_ff <= wdata_i & PCH_MASK; // RL1 RL25
      end
      if (hit(addr_i, `MPIR_ADDR_PD)) begin
        pd_ff <= wdata_i; // RL2
      end
      if (hit(addr_i, `MPIR_ADDR_OD)) begin
        od_ff <= wdata_i; // RL3
      end
      if (hit(addr_i, `MPIR_ADDR_PU)) begin
        pu_ff <= wdata_i; // RL4
      end
    end
  end

  // ****************************************
  // Option and direction registers
  // ****************************************
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      option_ff <= `MPIR_RST_OPTION; // RL15
    end else if (clk_en_i && option_load_i) begin
      option_ff <= working_operand_reg_i[6:0]; // RL14
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir_a_ff <= `MPIR_RST_DIR; // RL22
      dir_b_ff <= `MPIR_RST_DIR;
      dir_c_ff <= `MPIR_RST_DIR;
    end else if (clk_en_i && dir_load_instr_i) begin
      if (hit(dir_sel_i, `MPIR_DIR_SEL_A)) begin
        dir_a_ff <= working_operand_reg_i; // RL21
      end
      if (hit(dir_sel_i, `MPIR_DIR_SEL_B)) begin
        dir_b_ff <= working_operand_reg_i; // RL21
      end
      if (hit(dir_sel_i, `MPIR_DIR_SEL_C)) begin
        dir_c_ff <= working_operand_reg_i; // RL21
      end
    end
  end

  // ****************************************
  // Interrupt flags and mask
  // ****************************************
  always_comb begin
    events = 8'h00;
    events[`MPIR_BIT_TMR] = tmr_sync_ff && !tmr_last_ff;
    events[`MPIR_BIT_PCHG] = pchg_sync_ff && !pchg_last_ff;
    events[`MPIR_BIT_EXT] = flag_if.ext_edge_pulse;
  end

  // Set wins over a software clear in the same cycle
  always_comb begin
    nxt_flag = flag_ff;
    if (wr_flag) begin
      nxt_flag = wdata_i;
    end
    nxt_flag = (nxt_flag | events) & `MPIR_FLAG_IMPL; // RL11 RL12 RL13
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_ff <= `MPIR_RST_ZERO;
    end else if (clk_en_i) begin
      flag_ff <= nxt_flag;
    end
  end

  assign irq_hit = mask_ff[`MPIR_BIT_GIE] && |(events & mask_ff & `MPIR_FLAG_IMPL);
  assign wake_hit = |(events & mask_ff & `MPIR_FLAG_IMPL);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_ff <= `MPIR_RST_ZERO;
    end else if (clk_en_i) begin
      if (irq_hit) begin
        mask_ff[`MPIR_BIT_GIE] <= 1'b0; // RL9
      end else if (irq_return_instr_i) begin
        mask_ff[`MPIR_BIT_GIE] <= 1'b1; // RL10
      end else if (wr_mask) begin
        mask_ff[`MPIR_BIT_GIE] <= wdata_i[`MPIR_BIT_GIE];
      end
      if (wr_mask) begin
        mask_ff[2:0] <= wdata_i[2:0]; // RL5 RL6
      end
    end
  end

  // ****************************************
  // Sleep and vectoring
  // ****************************************
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= MPIR_RUN;
      wake_o <= 1'b0;
      vector_take_o <= 1'b0;
    end else if (clk_en_i) begin
      wake_o <= 1'b0;
      vector_take_o <= 1'b0;
      case (state_ff)
        MPIR_RUN: begin
          if (irq_hit) begin
            vector_take_o <= 1'b1;
            state_ff <= MPIR_SERVICE;
          end else if (sleep_instr_i) begin
            state_ff <= MPIR_SLEEP;
          end
        end
        MPIR_SLEEP: begin
          if (wake_hit) begin
            wake_o <= 1'b1;
            vector_take_o <= mask_ff[`MPIR_BIT_GIE]; // RL7 RL8
            state_ff <= mask_ff[`MPIR_BIT_GIE] ? MPIR_SERVICE : MPIR_RUN;
          end
        end
        MPIR_SERVICE: begin
          if (irq_hit) begin
            vector_take_o <= 1'b1; // RL9
          end else if (irq_return_instr_i) begin
            state_ff <= MPIR_RUN;
          end
        end
        default: begin
          state_ff <= MPIR_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // Read port and outputs
  // ****************************************
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `MPIR_RST_ZERO;
    end else if (clk_en_i && rd_en_i) begin
      case (addr_i)
        `MPIR_ADDR_PCHI: rdata_o <= pch_ff; // RL25
        `MPIR_ADDR_PD: rdata_o <= pd_ff;
        `MPIR_ADDR_OD: rdata_o <= od_ff;
        `MPIR_ADDR_PU: rdata_o <= pu_ff;
        `MPIR_ADDR_MASK: rdata_o <= mask_ff & `MPIR_MASK_IMPL; // RL6
        `MPIR_ADDR_FLAG: rdata_o <= flag_ff & mask_ff & `MPIR_FLAG_IMPL; // RL24 RL13
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_high_latch_o <= `MPIR_RST_ZERO;
      porta_pulldown_n_o <= RST_PD[3:0];
      portb_pulldown_n_o <= RST_PD[7:4];
      portb_opendrain_en_o <= `MPIR_RST_ZERO;
      portb_pullup_n_o <= `MPIR_RST_PULL;
      port_a_dir_o <= `MPIR_RST_DIR;
      port_b_dir_o <= `MPIR_RST_DIR;
      port_c_dir_o <= `MPIR_RST_DIR;
      prescale_ratio_o <= RST_OPT[2:0];
      prescale_target_o <= RST_OPT[`MPIR_OPT_PSA];
      counter_edge_select_o <= RST_OPT[`MPIR_OPT_SRCEDGE];
      timer_clk_select_o <= RST_OPT[`MPIR_OPT_CLKSEL];
      ext_edge_polarity_o <= RST_OPT[`MPIR_OPT_EDGE];
      sleeping_o <= 1'b0;
      vector_addr_o <= `MPIR_IRQ_VECTOR;
    end else if (clk_en_i) begin
      pc_high_latch_o <= pch_ff;
      porta_pulldown_n_o <= pd_ff[3:0] | dir_a_ff[3:0] ^ 4'hF; // RL2 RL23
      portb_pulldown_n_o <= pd_ff[7:4] | dir_b_ff[3:0] ^ 4'hF; // RL23
      portb_opendrain_en_o <= od_ff; // RL3
      portb_pullup_n_o <= pu_ff | ~dir_b_ff; // RL4 RL23
      port_a_dir_o <= dir_a_ff; // RL22
      port_b_dir_o <= dir_b_ff;
      port_c_dir_o <= dir_c_ff;
      prescale_ratio_o <= option_ff[2:0]; // RL16
      prescale_target_o <= option_ff[`MPIR_OPT_PSA]; // RL17
      counter_edge_select_o <= option_ff[`MPIR_OPT_SRCEDGE]; // RL18
      timer_clk_select_o <= option_ff[`MPIR_OPT_CLKSEL]; // RL19
      ext_edge_polarity_o <= option_ff[`MPIR_OPT_EDGE]; // RL20
      sleeping_o <= (state_ff == MPIR_SLEEP);
      vector_addr_o <= `MPIR_IRQ_VECTOR; // RL8
    end
  end
endmodule : mpir_regs
`default_nettype wire

// [inc/mpir_map.svh]
// Register offsets, field positions and reset values of the pin/interrupt/option bank
`ifndef MPIR_MAP_SVH
`define MPIR_MAP_SVH
`define MPIR_ADDR_PCHI 8'h0A
`define MPIR_ADDR_PD 8'h0B
`define MPIR_ADDR_OD 8'h0C
`define MPIR_ADDR_PU 8'h0D
`define MPIR_ADDR_MASK 8'h0E
`define MPIR_ADDR_FLAG 8'h0F
`define MPIR_DIR_SEL_A 8'h05
`define MPIR_DIR_SEL_B 8'h06
`define MPIR_DIR_SEL_C 8'h07
`define MPIR_BIT_TMR 0
`define MPIR_BIT_PCHG 1
`define MPIR_BIT_EXT 2
`define MPIR_BIT_GIE 7
`define MPIR_OPT_PSA 3
`define MPIR_OPT_SRCEDGE 4
`define MPIR_OPT_CLKSEL 5
`define MPIR_OPT_EDGE 6
`define MPIR_MASK_IMPL 8'h87
`define MPIR_FLAG_IMPL 8'h07
`define MPIR_RST_OPTION 7'h3F
`define MPIR_RST_DIR 8'hFF
`define MPIR_RST_PULL 8'hFF
`define MPIR_RST_ZERO 8'h00
`define MPIR_IRQ_VECTOR 11'h008
`endif

// [inc/mpir_pkg.sv]
// Types shared by the pin/interrupt/option register bank
`default_nettype none
package mpir_pkg;
  typedef enum logic [1:0] {
    MPIR_RUN,
    MPIR_SLEEP,
    MPIR_SERVICE
  } mpir_state_t;
  typedef logic [7:0] mpir_byte_t;
endpackage : mpir_pkg
`default_nettype wire

// [inc/mpir_flag_if.sv]
// Interface between the register bank and its edge detector
`default_nettype none
interface mpir_flag_if;
  logic ext_pin_sync;
  logic ext_edge_polarity;
  logic ext_edge_pulse;
  modport bank (output ext_pin_sync, output ext_edge_polarity, input ext_edge_pulse);
  modport det (input ext_pin_sync, input ext_edge_polarity, output ext_edge_pulse);
endinterface : mpir_flag_if
`default_nettype wire

// [core/mpir_edge_det.sv]
// Selected-edge detector for the external interrupt pin
`default_nettype none
module mpir_edge_det (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  mpir_flag_if.det flag_if
);
  logic last_ff;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_ff <= 1'b0;
    end else if (enable_i) begin
      last_ff <= flag_if.ext_pin_sync;
    end
  end

  // Rising when polarity is 1, falling when 0
  assign flag_if.ext_edge_pulse = enable_i &&
    (flag_if.ext_edge_polarity ? (flag_if.ext_pin_sync && !last_ff)
                               : (!flag_if.ext_pin_sync && last_ff)); // RL12 RL20
endmodule : mpir_edge_det
`default_nettype wire

// [test/mpir_regs_checker.sv]
// Assertion checker for the pin/interrupt/option register bank
`default_nettype none
module mpir_regs_checker #(
  parameter int PCH_BITS = 3
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_en_i,
  input wire logic option_load_i,
  input wire logic dir_load_instr_i,
  input wire logic [7:0] dir_sel_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] porta_pulldown_n_o,
  input wire logic [7:0] portb_pullup_n_o,
  input wire logic [7:0] port_a_dir_o,
  input wire logic [7:0] port_b_dir_o,
  input wire logic [7:0] port_c_dir_o,
  input wire logic [2:0] prescale_ratio_o,
  input wire logic prescale_target_o,
  input wire logic counter_edge_select_o,
  input wire logic timer_clk_select_o,
  input wire logic ext_edge_polarity_o,
  input wire logic wake_o,
  input wire logic vector_take_o,
  input wire logic [10:0] vector_addr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ****************************************
  // Properties
  // ****************************************
  property p_dir_rst;
    $rose(resetn_i) |-> (port_a_dir_o & port_b_dir_o & port_c_dir_o) == 8'hFF;
  endproperty
  a_dir_rst: assert property (p_dir_rst) else $error("direction reset value wrong");
  property p_opt_rst;
    $rose(resetn_i) |-> {ext_edge_polarity_o, timer_clk_select_o, counter_edge_select_o,
      prescale_target_o, prescale_ratio_o} == 7'h3F;
  endproperty
  a_opt_rst: assert property (p_opt_rst) else $error("option reset value wrong");
  property p_pull_off;
    ((porta_pulldown_n_o | port_a_dir_o[3:0]) == 4'hF) && ((portb_pullup_n_o | port_b_dir_o) == 8'hFF);
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull left on for output pin");
  property p_opt_chg;
    $changed(prescale_ratio_o) |-> $past(option_load_i && clk_en_i, 2) || $past(option_load_i && clk_en_i, 3);
  endproperty
  a_opt_chg: assert property (p_opt_chg) else $error("ratio changed without load");
  property p_dir_chg;
    $changed(port_b_dir_o) |-> $past(dir_load_instr_i && dir_sel_i == 8'h06, 2)
      || $past(dir_load_instr_i && dir_sel_i == 8'h06, 3);
  endproperty
  a_dir_chg: assert property (p_dir_chg) else $error("port b direction changed without load");
  property p_mask_rd;
    rd_en_i && clk_en_i && addr_i == 8'h0E |=> rdata_o[6:3] == 4'h0;
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask spare bits not zero");
  property p_flag_rd;
    rd_en_i && clk_en_i && addr_i == 8'h0F |=> rdata_o[7:3] == 5'h00;
  endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag spare bits not zero");
  property p_pch_rd;
    rd_en_i && clk_en_i && addr_i == 8'h0A |=> (rdata_o >> PCH_BITS) == 8'h00;
  endproperty
  a_pch_rd: assert property (p_pch_rd) else $error("latch spare bits not zero");
  property p_vec;
    vector_take_o |-> vector_addr_o == 11'h008 ##1 !vector_take_o;
  endproperty
  a_vec: assert property (p_vec) else $error("vector address or pulse wrong");
  c_vec: cover property (vector_take_o);
  c_wake: cover property (wake_o);
  c_opt: cover property (option_load_i);
endmodule : mpir_regs_checker
bind mpir_regs mpir_regs_checker #(.PCH_BITS(PCH_BITS)) u_chk (.clock_i, .resetn_i, .clk_en_i, .addr_i,
  .rd_en_i, .option_load_i, .dir_load_instr_i, .dir_sel_i, .rdata_o, .porta_pulldown_n_o, .portb_pullup_n_o,
  .port_a_dir_o, .port_b_dir_o, .port_c_dir_o, .prescale_ratio_o, .prescale_target_o, .counter_edge_select_o,
  .timer_clk_select_o, .ext_edge_polarity_o, .wake_o, .vector_take_o, .vector_addr_o);
`default_nettype wire

// [test/mpir_core_model.sv]
// Processor core model issuing register accesses and special instructions
`default_nettype none
module mpir_core_model (
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output logic clk_en_o,
  output logic [7:0] addr_o,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] wdata_o,
  output logic [7:0] acc_o,
  output logic option_load_o,
  output logic dir_load_o,
  output logic [7:0] dir_sel_o,
  output logic irq_return_o,
  output logic sleep_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {addr_o, wr_en_o, rd_en_o, wdata_o, acc_o} = {8'h00, 1'b0, 1'b0, 8'h00, 8'h00};
    {option_load_o, dir_load_o, dir_sel_o, irq_return_o, sleep_o} = 12'h000;
  end
  task automatic hold(input logic e);
    @(posedge clock_i) #1;
    clk_en_o = e;
  endtask : hold
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) #1;
    {addr_o, wdata_o, wr_en_o} = {a, d, 1'b1};
    @(posedge clock_i) #1;
    {addr_o, wdata_o, wr_en_o} = {~a, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i) #1;
    {addr_o, rd_en_o} = {a, 1'b1};
    @(posedge clock_i) #1;
    {addr_o, rd_en_o} = {~a, 1'b0};
    d = rdata_i;
  endtask : rd
  // Kind 0 option, 1 direction, 2 return, 3 sleep
  task automatic op(input int k, input logic [7:0] a, input logic [7:0] s);
    @(posedge clock_i) #1;
    {acc_o, dir_sel_o} = {a, s};
    {option_load_o, dir_load_o, irq_return_o, sleep_o} = 4'h1 << (3 - k);
    @(posedge clock_i) #1;
    {option_load_o, dir_load_o, irq_return_o, sleep_o, dir_sel_o} = {4'h0, ~s};
  endtask : op
endmodule : mpir_core_model
`default_nettype wire

// [test/testbench.sv]
// Self-checking testbench for the pin/interrupt/option register bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic clk_en_i, wr_en_i, rd_en_i, option_load_i, dir_load_instr_i, irq_return_instr_i, sleep_instr_i;
  logic timer_ovf_i = 1'b0, port_change_i = 1'b0, ext_pin_i = 1'b0;
  logic [7:0] addr_i, wdata_i, working_operand_reg_i, dir_sel_i, rdata_o, pc_high_latch_o, rv;
  logic [7:0] portb_opendrain_en_o, portb_pullup_n_o, port_a_dir_o, port_b_dir_o, port_c_dir_o;
  logic [3:0] porta_pulldown_n_o, portb_pulldown_n_o;
  logic [2:0] prescale_ratio_o;
  logic prescale_target_o, counter_edge_select_o, timer_clk_select_o, ext_edge_polarity_o;
  logic sleeping_o, wake_o, vector_take_o;
  logic [10:0] vector_addr_o;
  int fail_count = 0, check_count = 0, wake_n = 0, vec_n = 0, w0, v0;
  logic [7:0] exp_ff [5] = '{8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h87};
  logic [7:0] dir_v [3] = '{8'h00, 8'hF0, 8'h5A};
  logic [7:0] opt_v [2] = '{8'h2A, 8'hD5};
  always #2 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (wake_o === 1'b1) wake_n++;
    if (vector_take_o === 1'b1) vec_n++;
  end
  mpir_core_model core (.clock_i, .rdata_i(rdata_o), .clk_en_o(clk_en_i), .addr_o(addr_i), .wr_en_o(wr_en_i),
    .rd_en_o(rd_en_i), .wdata_o(wdata_i), .acc_o(working_operand_reg_i), .option_load_o(option_load_i),
    .dir_load_o(dir_load_instr_i), .dir_sel_o(dir_sel_i), .irq_return_o(irq_return_instr_i), .sleep_o(sleep_instr_i));
  mpir_regs #(.PCH_BITS(3)) dut (.clock_i, .resetn_i, .clk_en_i, .addr_i, .wr_en_i, .rd_en_i, .wdata_i,
    .working_operand_reg_i, .option_load_i, .dir_load_instr_i, .dir_sel_i, .irq_return_instr_i, .sleep_instr_i,
    .timer_ovf_i, .port_change_i, .ext_pin_i, .rdata_o, .pc_high_latch_o, .porta_pulldown_n_o,
    .portb_pulldown_n_o, .portb_opendrain_en_o, .portb_pullup_n_o, .port_a_dir_o, .port_b_dir_o, .port_c_dir_o,
    .prescale_ratio_o, .prescale_target_o, .counter_edge_select_o, .timer_clk_select_o, .ext_edge_polarity_o,
    .sleeping_o, .wake_o, .vector_take_o, .vector_addr_o);
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic pulse(input int k);
    @(posedge clock_i) #1;
    {timer_ovf_i, port_change_i, ext_pin_i} = {k == 0, k == 1, k == 2};
    repeat (2) @(posedge clock_i);
    #1 {timer_ovf_i, port_change_i, ext_pin_i} = 3'b000;
    repeat (6) @(posedge clock_i);
  endtask : pulse
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #(4 * 5000);
    fail_count++;
    complete_run();
  end
  function automatic logic [7:0] opt_now();
    return {1'b0, ext_edge_polarity_o, timer_clk_select_o, counter_edge_select_o, prescale_target_o,
      prescale_ratio_o};
  endfunction : opt_now
  initial begin
    core.hold(1'b1);
    repeat (4) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    chk("pd_a", {4'h0, porta_pulldown_n_o}, 8'h0F);
    chk("dir_c", port_c_dir_o, 8'hFF);
    chk("option", opt_now(), 8'h3F);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      core.wr(8'h0A + i[7:0], 8'hFF);
      core.rd(8'h0A + i[7:0], rv);
      chk("reg", rv, exp_ff[i]);
    end
    chk("pch_out", pc_high_latch_o, 8'h07);
    core.rd(8'h10, rv);
    chk("unmapped", rv, 8'h00);
    core.rd(8'h0F, rv);
    chk("flags", rv, 8'h00);
    $display("register test done");
    core.wr(8'h0B, 8'h00);
    core.wr(8'h0C, 8'hA5);
    core.wr(8'h0D, 8'h3C);
    repeat (3) @(posedge clock_i);
    chk("pd", {portb_pulldown_n_o, porta_pulldown_n_o}, 8'h00);
    chk("od", portb_opendrain_en_o, 8'hA5);
    chk("pu", portb_pullup_n_o, 8'h3C);
    for (int i = 0; i < 3; i++) core.op(1, dir_v[i], 8'h05 + i[7:0]);
    repeat (3) @(posedge clock_i);
    chk("dir_a", port_a_dir_o, 8'h00);
    chk("dir_b", port_b_dir_o, 8'hF0);
    chk("dir_c", port_c_dir_o, 8'h5A);
    chk("pd_out", {portb_pulldown_n_o, porta_pulldown_n_o}, 8'hFF);
    chk("pu_out", portb_pullup_n_o, 8'h3F);
    core.hold(1'b0);
    core.wr(8'h0C, 8'h00);
    core.hold(1'b1);
    core.rd(8'h0C, rv);
    chk("frozen", rv, 8'hA5);
    $display("pin test done");
    for (int i = 0; i < 2; i++) begin
      core.op(0, opt_v[i], 8'h00);
      repeat (3) @(posedge clock_i);
      chk("option", opt_now(), opt_v[i] & 8'h7F);
    end
    $display("option test done");
    core.wr(8'h0F, 8'h00);
    core.wr(8'h0E, 8'h07);
    for (int k = 0; k < 3; k++) begin
      pulse(k);
      core.rd(8'h0F, rv);
      chk("flag", rv, 8'((2 << k) - 1));
    end
    core.wr(8'h0E, 8'h00);
    core.rd(8'h0F, rv);
    chk("flag_masked", rv, 8'h00);
    core.wr(8'h0F, 8'h00);
    core.wr(8'h0E, 8'h07);
    core.rd(8'h0F, rv);
    chk("flag_clear", rv, 8'h00);
    $display("flag test done");
    core.wr(8'h0E, 8'h81);
    v0 = vec_n;
    pulse(0);
    chk("taken", 8'(vec_n - v0), 8'h01);
    core.rd(8'h0E, rv);
    chk("gie_off", rv, 8'h01);
    core.wr(8'h0F, 8'h00);
    core.op(2, 8'h00, 8'h00);
    core.rd(8'h0E, rv);
    chk("gie_on", rv, 8'h81);
    $display("interrupt test done");
    core.wr(8'h0F, 8'h00);
    core.wr(8'h0E, 8'h01);
    core.op(3, 8'h00, 8'h00);
    repeat (2) @(posedge clock_i);
    chk("sleep", {7'h00, sleeping_o}, 8'h01);
    {w0, v0} = {wake_n, vec_n};
    pulse(0);
    chk("wake", 8'(wake_n - w0), 8'h01);
    chk("no_vec", 8'(vec_n - v0), 8'h00);
    core.wr(8'h0F, 8'h00);
    core.wr(8'h0E, 8'h81);
    core.op(3, 8'h00, 8'h00);
    repeat (2) @(posedge clock_i);
    v0 = vec_n;
    pulse(0);
    chk("vec", 8'(vec_n - v0), 8'h01);
    chk("vaddr", vector_addr_o[7:0], 8'h08);
    $display("sleep test done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
